// [logic/link_speed_negotiation_timers.sv]
// Summary of operation
// - A watchdog restarts negotiation when no passed sync test has been seen for 1620 ms.
// - Watchdog timing starts on entry to the master stage, and a signal-loss drop counts as a passed test.
// - Watchdog checks are spaced by no more than 32 ms, with no minimum spacing.
// - A watchdog check is made next to every sync test, so the interval is one receive cycle plus overhead.
// - Once the recording window has elapsed the transmit speed list may be cut to the detected speeds.
// - The recording window is 1652 ms so a watchdog restart always comes before an empty list.
// - Entry by a passed sync test records that speed at once, entry by signal-loss drop records none.
// - The recording counter is preloaded with 370 ms in state 12 or 5B, so the window ends 1282 ms after entry.
// - An inactive port cycles its receiver slowly for a sleep period of at most 5000 ms.
// - In the low-load stage each transmit speed is held between one and one-plus-a-receive-cycle transmit cycles.
// - In the low-load stage the receiver steps at the transmit rate, returning periodically to the fast rate.
// - Each fast search period in the low-load stage lasts at least 900 ms.
// - Each receive cycle lasts from 2 ms to 30 ms, or 154 ms while the low-load stage sleeps.
// - The master transmit cycle is 154 ms.
// - The speed stability time is 217 ms.
module link_speed_negotiation_timers #(
    parameter int CYCLES_PER_MS = negt_pkg::CYCLES_PER_MS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Negotiation events from the stage machine
    input wire logic restart_neg,
    input wire logic master_entry_sync,
    input wire logic master_entry_los,
    input wire logic negotiating,
    input wire logic sync_test,
    input wire logic sync_pass,
    input wire logic receive_signal_loss,
    input wire logic peer_speed_change,
    input wire logic low_load,
    // Timer results
    output logic watchdog_restart,
    output logic watchdog_check,
    output logic record_speed,
    output logic trim_ready,
    output logic rx_step,
    output logic tx_step,
    output logic fast_search,
    output logic sleeping,
    output logic speed_stable,
    // Interrupt
    output logic irq
);
    localparam int MSW = negt_pkg::MSW;

    generate
        if (CYCLES_PER_MS < 2) begin : g_bad
            $error("CYCLES_PER_MS must be at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [MSW-1:0] wd_cnt;
        logic [MSW-1:0] chk_cnt;
        logic [MSW-1:0] nc_cnt;
        logic [MSW-1:0] rx_cnt;
        logic [MSW-1:0] tx_cnt;
        logic [MSW-1:0] sl_cnt;
        logic [MSW-1:0] st_cnt;
        logic wd_armed;
        logic nc_active;
        logic los_q;
        logic stable;
        negt_pkg::slow_t slow;
        logic rx_step;
        logic tx_step;
        logic wd_check;
        logic wd_fire;
        logic record_speed;
        logic [1:0] ctrl;
        logic [4:0] rxcyc;
        logic [MSW-1:0] sleep_ms;
        logic [negt_pkg::NUM_EV-1:0] irq_stat;
        logic [negt_pkg::NUM_EV-1:0] irq_mask;
        logic [31:0] prdata;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    logic tick;

    // ==========================================================
    // Common millisecond time base
    // ==========================================================
    ms_tick #(
        .CYCLES(CYCLES_PER_MS)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .clear(restart_neg),
        .tick(tick)
    );

    // Saturating millisecond increment so idle counters never wrap
    function automatic logic [MSW-1:0] inc(input logic [MSW-1:0] v);
        inc = (v == {MSW{1'b1}}) ? v : v + 1'b1;
    endfunction

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        logic los_drop;
        logic entry;
        logic wd_reload;
        logic chk_due;
        logic [MSW-1:0] wd_base;
        logic [MSW-1:0] rx_period;
        logic trim_now;
        logic [negt_pkg::NUM_EV-1:0] ev;
        logic [negt_pkg::NUM_EV-1:0] w1c;
        logic wr;
        logic [4:0] rx_w;
        logic [MSW-1:0] sl_w;
        los_drop = 1'b0;
        entry = 1'b0;
        wd_reload = 1'b0;
        chk_due = 1'b0;
        wd_base = '0;
        rx_period = '0;
        trim_now = 1'b0;
        ev = '0;
        w1c = '0;
        wr = 1'b0;
        rx_w = '0;
        sl_w = '0;
        s_nxt = s_r;
        s_nxt.rx_step = 1'b0;
        s_nxt.tx_step = 1'b0;
        s_nxt.wd_check = 1'b0;
        s_nxt.wd_fire = 1'b0;
        s_nxt.record_speed = 1'b0;
        s_nxt.los_q = receive_signal_loss;

        los_drop = s_r.los_q && !receive_signal_loss;
        entry = master_entry_sync || master_entry_los;

        // Millisecond advance of every timer; the watchdog and recording counters advance only while armed or active
        if (tick) begin
            s_nxt.wd_cnt = s_r.wd_armed ? inc(s_r.wd_cnt) : s_r.wd_cnt;
            s_nxt.chk_cnt = inc(s_r.chk_cnt);
            s_nxt.nc_cnt = s_r.nc_active ? inc(s_r.nc_cnt) : s_r.nc_cnt;
            s_nxt.rx_cnt = inc(s_r.rx_cnt);
            s_nxt.tx_cnt = inc(s_r.tx_cnt);
            s_nxt.sl_cnt = inc(s_r.sl_cnt);
            s_nxt.st_cnt = inc(s_r.st_cnt);
        end

        // Watchdog reload; a signal-loss drop is as good as a passed test
        wd_reload = entry || (negotiating && (sync_pass || los_drop));
        wd_base = wd_reload ? '0 : s_r.wd_cnt;
        if (wd_reload) begin
            s_nxt.wd_cnt = '0;
        end
        if (entry) begin
            s_nxt.wd_armed = 1'b1;
            s_nxt.chk_cnt = '0;
            s_nxt.nc_active = 1'b1;
            s_nxt.nc_cnt = master_entry_sync ? negt_pkg::T_NCINIT_MS : '0;
            s_nxt.record_speed = master_entry_sync;
        end

        // Check beside each sync test, forced if 32 ms go by without one
        chk_due = sync_test || (tick && s_r.chk_cnt >= negt_pkg::T_WDDLY_MAX_MS - 1'b1);
        if (s_r.wd_armed && chk_due && !entry) begin
            s_nxt.wd_check = 1'b1;
            s_nxt.chk_cnt = '0;
            if (wd_base >= negt_pkg::T_FAIL_MS) begin
                s_nxt.wd_fire = 1'b1;
                s_nxt.wd_armed = 1'b0;
                s_nxt.nc_active = 1'b0;
            end
        end

        // Receive cycle: programmed 2..30 ms, or transmit rate while asleep
        if (s_r.slow == negt_pkg::SLOW_SLEEP) begin
            rx_period = negt_pkg::T_TXCYCL_MS;
        end else begin
            rx_period = {{(MSW - 5){1'b0}}, s_r.rxcyc};
        end
        if (tick && s_r.rx_cnt >= rx_period - 1'b1) begin
            s_nxt.rx_step = 1'b1;
            s_nxt.rx_cnt = '0;
        end

        // Outside sleep the transmit dwell is only tested once per receive cycle, so it lands in 154..183 ms
        if (s_r.slow == negt_pkg::SLOW_SLEEP) begin
            if (tick && s_r.tx_cnt >= negt_pkg::T_TXCYCL_MS - 1'b1) begin
                s_nxt.tx_step = 1'b1;
                s_nxt.tx_cnt = '0;
            end
        end else if (s_nxt.rx_step && s_nxt.tx_cnt >= negt_pkg::T_TXCYCL_MS) begin
            s_nxt.tx_step = 1'b1;
            s_nxt.tx_cnt = '0;
        end

        // Low-load stage: sleep, then a fast search wake period
        if (!low_load || !s_r.ctrl[negt_pkg::CTRL_SLOW_EN]) begin
            s_nxt.slow = negt_pkg::SLOW_OFF;
            s_nxt.sl_cnt = '0;
        end else begin
            case (s_r.slow)
                negt_pkg::SLOW_OFF: begin
                    s_nxt.slow = negt_pkg::SLOW_SLEEP;
                    s_nxt.sl_cnt = '0;
                end
                negt_pkg::SLOW_SLEEP: begin
                    if (tick && s_r.sl_cnt >= s_r.sleep_ms - 1'b1) begin
                        s_nxt.slow = negt_pkg::SLOW_WAKE;
                        s_nxt.sl_cnt = '0;
                        ev[negt_pkg::EV_WAKE] = 1'b1;
                    end
                end
                negt_pkg::SLOW_WAKE: begin
                    if (tick && s_r.sl_cnt >= negt_pkg::T_WAKE_MS - 1'b1) begin
                        s_nxt.slow = negt_pkg::SLOW_SLEEP;
                        s_nxt.sl_cnt = '0;
                    end
                end
                default: begin
                    s_nxt.slow = negt_pkg::SLOW_OFF;
                    s_nxt.sl_cnt = '0;
                end
            endcase
        end

        // Stability: the peer has held its speed for 217 ms
        if (peer_speed_change) begin
            s_nxt.st_cnt = '0;
            s_nxt.stable = 1'b0;
        end else if (!s_r.stable && s_r.st_cnt >= negt_pkg::T_STBL_MS) begin
            s_nxt.stable = 1'b1;
            ev[negt_pkg::EV_STBL] = 1'b1;
        end

        // Recording window elapsed; list trimming allowed
        trim_now = s_r.nc_active && s_r.nc_cnt >= negt_pkg::T_NCYCL_MS;
        ev[negt_pkg::EV_TRIM] = trim_now && !(s_r.nc_active && s_r.nc_cnt == negt_pkg::T_NCYCL_MS + 1'b1)
            && s_r.nc_cnt == negt_pkg::T_NCYCL_MS && tick;
        ev[negt_pkg::EV_WD] = s_nxt.wd_fire;

        // Restart clears every timer
        if (restart_neg) begin
            s_nxt.wd_cnt = '0;
            s_nxt.chk_cnt = '0;
            s_nxt.nc_cnt = '0;
            s_nxt.rx_cnt = '0;
            s_nxt.tx_cnt = '0;
            s_nxt.sl_cnt = '0;
            s_nxt.st_cnt = '0;
            s_nxt.wd_armed = 1'b0;
            s_nxt.nc_active = 1'b0;
            s_nxt.stable = 1'b0;
            s_nxt.rx_step = 1'b0;
            s_nxt.tx_step = 1'b0;
        end

        // APB writes take effect in the access phase
        wr = psel && penable && pwrite;
        rx_w = pwdata[4:0];
        if (rx_w < negt_pkg::T_RXCYCL_MIN_MS) begin
            rx_w = negt_pkg::T_RXCYCL_MIN_MS;
        end else if (rx_w > negt_pkg::T_RXCYCL_MAX_MS) begin
            rx_w = negt_pkg::T_RXCYCL_MAX_MS;
        end
        sl_w = pwdata[MSW-1:0];
        if (sl_w > negt_pkg::T_SLEEP_MS) begin
            sl_w = negt_pkg::T_SLEEP_MS;
        end else if (sl_w == '0) begin
            sl_w = {{(MSW - 1){1'b0}}, 1'b1};
        end
        if (wr) begin
            case (paddr)
                negt_pkg::OFF_CTRL: s_nxt.ctrl = pwdata[1:0];
                negt_pkg::OFF_RXCYC: s_nxt.rxcyc = rx_w;
                negt_pkg::OFF_SLEEP: s_nxt.sleep_ms = sl_w;
                negt_pkg::OFF_IRQ_STAT: w1c = pwdata[negt_pkg::NUM_EV-1:0];
                negt_pkg::OFF_IRQ_MASK: s_nxt.irq_mask = pwdata[negt_pkg::NUM_EV-1:0];
                default: ;
            endcase
        end
        // A new event outranks a clear in the same cycle
        s_nxt.irq_stat = (s_r.irq_stat & ~w1c) | ev;

        // Read data is captured in the setup phase, stable through access
        if (psel && !penable && !pwrite) begin
            case (paddr)
                negt_pkg::OFF_CTRL: s_nxt.prdata = {30'h0, s_r.ctrl};
                negt_pkg::OFF_RXCYC: s_nxt.prdata = {27'h0, s_r.rxcyc};
                negt_pkg::OFF_SLEEP: s_nxt.prdata = {19'h0, s_r.sleep_ms};
                negt_pkg::OFF_STAT: s_nxt.prdata = {27'h0, s_r.wd_armed, s_r.stable,
                    s_r.slow == negt_pkg::SLOW_SLEEP, s_r.slow == negt_pkg::SLOW_WAKE, trim_now};
                negt_pkg::OFF_IRQ_STAT: s_nxt.prdata = {28'h0, s_r.irq_stat};
                negt_pkg::OFF_IRQ_MASK: s_nxt.prdata = {28'h0, s_r.irq_mask};
                negt_pkg::OFF_WD_CNT: s_nxt.prdata = {19'h0, s_r.wd_cnt};
                negt_pkg::OFF_NC_CNT: s_nxt.prdata = {19'h0, s_r.nc_cnt};
                default: s_nxt.prdata = 32'h0;
            endcase
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.los_q <= 1'b1;
            s_r.slow <= negt_pkg::SLOW_OFF;
            s_r.ctrl <= negt_pkg::CTRL_RESET;
            s_r.rxcyc <= negt_pkg::RXCYC_RESET;
            s_r.sleep_ms <= negt_pkg::SLEEP_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // Zero-wait APB: unmapped addresses answer with an error
    always_comb begin
        pready = 1'b1;
        pslverr = 1'b0;
        if (psel && penable && paddr > negt_pkg::OFF_NC_CNT) begin
            pslverr = 1'b1;
        end
        if (psel && penable && paddr[1:0] != 2'b00) begin
            pslverr = 1'b1;
        end
    end

    assign prdata = s_r.prdata;
    assign watchdog_restart = s_r.wd_fire;
    assign watchdog_check = s_r.wd_check;
    assign record_speed = s_r.record_speed;
    // Trimming stays a level so the stage machine may act whenever convenient
    assign trim_ready = s_r.nc_active && s_r.nc_cnt >= negt_pkg::T_NCYCL_MS
        && s_r.ctrl[negt_pkg::CTRL_TRIM_EN];
    assign rx_step = s_r.rx_step;
    assign tx_step = s_r.tx_step;
    assign fast_search = s_r.slow == negt_pkg::SLOW_WAKE;
    assign sleeping = s_r.slow == negt_pkg::SLOW_SLEEP;
    assign speed_stable = s_r.stable;
    assign irq = |(s_r.irq_stat & s_r.irq_mask);
endmodule // link_speed_negotiation_timers

// [common/negt_pkg.sv]
package negt_pkg;
    // ==========================================================
    // Clock and time base
    // ==========================================================
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYCLES_PER_MS = CLK_FREQ_HZ / MS_PER_S;
    localparam int MSW = 13;

    // ==========================================================
    // Negotiation times in milliseconds
    // ==========================================================
    localparam logic [MSW-1:0] T_FAIL_MS = 13'd1620;
    localparam logic [MSW-1:0] T_WDDLY_MAX_MS = 13'd32;
    localparam logic [MSW-1:0] T_NCYCL_MS = 13'd1652;
    localparam logic [MSW-1:0] T_NCINIT_MS = 13'd370;
    localparam logic [MSW-1:0] T_SLEEP_MS = 13'd5000;
    localparam logic [MSW-1:0] T_TXCYCL_MS = 13'd154;
    localparam logic [MSW-1:0] T_STBL_MS = 13'd217;
    localparam logic [MSW-1:0] T_WAKE_MS = 13'd900;
    localparam logic [4:0] T_RXCYCL_MIN_MS = 5'd2;
    localparam logic [4:0] T_RXCYCL_MAX_MS = 5'd30;

    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_RXCYC = 8'h04;
    localparam logic [7:0] OFF_SLEEP = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFF_WD_CNT = 8'h18;
    localparam logic [7:0] OFF_NC_CNT = 8'h1c;

    // Control fields and reset values
    localparam int CTRL_TRIM_EN = 0;
    localparam int CTRL_SLOW_EN = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam logic [4:0] RXCYC_RESET = 5'h1e;
    localparam logic [12:0] SLEEP_RESET = 13'h1388;

    // Status fields
    localparam int STAT_TRIM = 0;
    localparam int STAT_FAST = 1;
    localparam int STAT_SLEEP = 2;
    localparam int STAT_STABLE = 3;
    localparam int STAT_WD_ARMED = 4;

    // Interrupt event bits
    localparam int NUM_EV = 4;
    localparam int EV_WD = 0;
    localparam int EV_TRIM = 1;
    localparam int EV_WAKE = 2;
    localparam int EV_STBL = 3;

    // Low-load waiting stage modes
    typedef enum logic [2:0] {
        SLOW_OFF = 3'b001,
        SLOW_SLEEP = 3'b010,
        SLOW_WAKE = 3'b100
    } slow_t;
endpackage

// [logic/ms_tick.sv]
// ==========================================================
// Millisecond tick generator
// ==========================================================
module ms_tick #(
    parameter int CYCLES = 100000
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic clear,
    // Tick out
    output logic tick
);
    localparam int CW = $clog2(CYCLES);

    generate
        if (CYCLES < 2) begin : g_bad
            $error("ms_tick needs at least two cycles per tick");
        end
    endgenerate

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic tick_nxt;

    // Restarting the divider keeps every timer phase-aligned with negotiation
    always_comb begin
        tick_nxt = 1'b0;
        cnt_nxt = cnt_r + 1'b1;
        if (clear) begin
            cnt_nxt = '0;
        end else if (cnt_r == CW'(CYCLES - 1)) begin
            cnt_nxt = '0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick <= tick_nxt;
        end
    end
endmodule // ms_tick

// [verification/negt_sva.sv]
// ========================================
// Timer checks at the block boundary
// ========================================
module negt_sva #(
    parameter int CYCLES_PER_MS = 10
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pslverr,
    // Negotiation events
    input wire logic restart_neg,
    input wire logic master_entry_sync,
    input wire logic master_entry_los,
    input wire logic negotiating,
    input wire logic sync_pass,
    input wire logic peer_speed_change,
    input wire logic low_load,
    // Timer results
    input wire logic watchdog_restart,
    input wire logic watchdog_check,
    input wire logic record_speed,
    input wire logic rx_step,
    input wire logic tx_step,
    input wire logic fast_search,
    input wire logic sleeping,
    input wire logic speed_stable
);
    logic [31:0] since_chg_r;
    logic [31:0] since_rx_r;
    logic rx_seen_r;
    logic [31:0] since_tx_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Gap counters; restarts, entries and low-load clear the receive-cycle seen flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_chg_r <= 32'h0;
            since_rx_r <= 32'h0;
            rx_seen_r <= 1'b0;
            since_tx_r <= 32'h0;
        end else begin
            since_tx_r <= (tx_step || restart_neg) ? 32'h0 : since_tx_r + 32'h1;
            since_chg_r <= (peer_speed_change || restart_neg) ? 32'h0 : since_chg_r + 32'h1;
            since_rx_r <= rx_step ? 32'h0 : since_rx_r + 32'h1;
            rx_seen_r <= (restart_neg || low_load || master_entry_sync || master_entry_los) ? 1'b0 : rx_seen_r || rx_step;
        end
    end

    // Pass, then a quiet watchdog
    sequence s_pass;
        sync_pass && negotiating;
    endsequence
    sequence s_quiet;
        !watchdog_restart [*7];
    endsequence

    a_entry_records: assert property (master_entry_sync |=> record_speed)
        else $error("record pulse missing after entry");
    a_record_cause: assert property (record_speed |-> $past(master_entry_sync))
        else $error("record pulse without entry by passed test");
    a_restart_at_check: assert property (watchdog_restart |-> watchdog_check || $past(watchdog_check))
        else $error("watchdog restart without a check");
    a_restart_single: assert property (watchdog_restart |=> !watchdog_restart)
        else $error("watchdog restart longer than one cycle");
    a_reload_quiet: assert property (s_pass |-> ##2 s_quiet)
        else $error("watchdog restart right after a passed test");
    a_stable_time: assert property ($rose(speed_stable) |->
        since_chg_r >= 216 * CYCLES_PER_MS && since_chg_r <= 218 * CYCLES_PER_MS + 2)
        else $error("stability flag at wrong time");
    a_change_unstable: assert property (peer_speed_change |=> !speed_stable)
        else $error("stability flag kept over a speed change");
    a_sleep_fast_excl: assert property (!(sleeping && fast_search))
        else $error("sleep and fast search together");
    a_rx_min_gap: assert property (rx_step && rx_seen_r |-> since_rx_r >= 2 * CYCLES_PER_MS - 1)
        else $error("receive cycle shorter than minimum");
    a_tx_dwell_min: assert property (tx_step |-> since_tx_r >= 152 * CYCLES_PER_MS)
        else $error("transmit dwell shorter than minimum");
    a_slverr_unmapped: assert property (psel && penable && paddr > 8'h1c |-> pslverr)
        else $error("unmapped access not refused");
endmodule // negt_sva

bind link_speed_negotiation_timers negt_sva #(.CYCLES_PER_MS(CYCLES_PER_MS)) sva_i (.*);

// [verification/peer_port.sv]
// ========================================
// Peer port seen across the link
// ========================================
module peer_port (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Behaviour set by the bench
    input wire logic en,
    input wire logic pass_en,
    input wire logic [15:0] period,
    // What the local receiver observes
    output logic sync_test,
    output logic sync_pass,
    output logic receive_signal_loss
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt_r;
    logic last;

    assign last = (cnt_r == period - 16'h1);

    // One test ends each period; no signal, no test
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 16'h0;
            sync_test <= 1'b0;
            sync_pass <= 1'b0;
            receive_signal_loss <= 1'b1;
        end else begin
            receive_signal_loss <= ~en;
            sync_test <= en && last;
            sync_pass <= en && pass_en && last;
            cnt_r <= (!en || last) ? 16'h0 : cnt_r + 16'h1;
        end
    end
endmodule // peer_port

// [verification/tb_top.sv]
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int C = 10;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic restart_neg, master_entry_sync, master_entry_los, negotiating, sync_test, sync_pass;
    logic receive_signal_loss, peer_speed_change, low_load, pe_en, pe_pass;
    logic watchdog_restart, watchdog_check, record_speed, trim_ready, rx_step, tx_step;
    logic fast_search, sleeping, speed_stable, irq;
    logic [15:0] pe_per;
    logic [3:0] obs;
    logic [32:0] rq[$];
    int fail_count, check_count, rec_n, wd_n, n, seed;

    assign obs = {fast_search, speed_stable, trim_ready, watchdog_restart};

    link_speed_negotiation_timers #(.CYCLES_PER_MS(C)) uut (.*);
    peer_port peer (.pclk, .presetn, .en(pe_en), .pass_en(pe_pass), .period(pe_per), .sync_test, .sync_pass,
        .receive_signal_loss);

    // ========================================
    // Checking and closing
    // ========================================
    task chk(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task conclude;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ========================================
    // Drivers
    // ========================================
    // One transfer; pready is polled
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            fail_count++;
            conclude();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reads queue their expected answer
    task rd(input logic [7:0] a, input logic [31:0] v, input logic e);
        rq.push_back({e, v});
        apb(1'b0, a, 32'h0);
    endtask

    task strobe(input int k);
        @(posedge pclk);
        case (k)
            0: restart_neg <= 1'b1;
            1: master_entry_sync <= 1'b1;
            2: master_entry_los <= 1'b1;
            default: peer_speed_change <= 1'b1;
        endcase
        @(posedge pclk);
        {restart_neg, master_entry_sync, master_entry_los, peer_speed_change} <= 4'h0;
    endtask

    // Sampled on the falling edge, away from updates
    task waitv(input int b, input logic v, input int lim);
        n = 0;
        while (obs[b] !== v) begin
            @(negedge pclk);
            n++;
            if (n > lim) begin
                fail_count++;
                conclude();
            end
        end
    endtask

    // Monitor pops a note at each read
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, rq.pop_front());
        if (record_speed === 1'b1) rec_n++;
        if (watchdog_restart === 1'b1) wd_n++;
    end

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ========================================
    // Main sequence
    // ========================================
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {restart_neg, master_entry_sync, master_entry_los, peer_speed_change, low_load} = '0;
        {pe_en, pe_pass, negotiating} = '0;
        pe_per = 16'd200;
        seed = 32'h81edd58c;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(negt_pkg::OFF_CTRL, 32'(negt_pkg::CTRL_RESET), 1'b0);
        rd(negt_pkg::OFF_RXCYC, 32'(negt_pkg::T_RXCYCL_MAX_MS), 1'b0);
        rd(negt_pkg::OFF_SLEEP, 32'(negt_pkg::T_SLEEP_MS), 1'b0);
        rd(8'h20, 32'h0, 1'b1);
        rd(8'h02, 32'h0, 1'b1);
        apb(1'b1, negt_pkg::OFF_RXCYC, 32'h1);
        rd(negt_pkg::OFF_RXCYC, 32'(negt_pkg::T_RXCYCL_MIN_MS), 1'b0);
        apb(1'b1, negt_pkg::OFF_RXCYC, 32'h1f);
        rd(negt_pkg::OFF_RXCYC, 32'(negt_pkg::T_RXCYCL_MAX_MS), 1'b0);
        apb(1'b1, negt_pkg::OFF_SLEEP, 32'h1770);
        rd(negt_pkg::OFF_SLEEP, 32'(negt_pkg::T_SLEEP_MS), 1'b0);
        negotiating <= 1'b1;
        strobe(0);
        strobe(1);
        rd(negt_pkg::OFF_NC_CNT, 32'(negt_pkg::T_NCINIT_MS), 1'b0);
        chk(33'(rec_n), 33'h1);
        // Entry by signal detect; failing tests let the watchdog expire
        apb(1'b1, negt_pkg::OFF_IRQ_MASK, 32'h0);
        apb(1'b1, negt_pkg::OFF_IRQ_STAT, 32'hf);
        pe_per <= 16'((2 + {$random(seed)} % 29) * C);
        strobe(0);
        pe_en <= 1'b1;
        strobe(2);
        rd(negt_pkg::OFF_NC_CNT, 32'h0, 1'b0);
        chk(33'(rec_n), 33'h1);
        waitv(0, 1'b1, 1700 * C);
        chk(33'(n >= 1610 * C && n <= 1653 * C), 33'h1);
        chk(33'(irq), 33'h0);
        apb(1'b1, negt_pkg::OFF_IRQ_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        chk(33'(irq), 33'h1);
        apb(1'b1, negt_pkg::OFF_IRQ_STAT, 32'h1);
        repeat (2) @(posedge pclk);
        chk(33'(irq), 33'h0);
        // Passing tests hold the watchdog off
        pe_pass <= 1'b1;
        strobe(0);
        wd_n = 0;
        strobe(1);
        waitv(1, 1'b1, 1300 * C);
        chk(33'(n >= 1281 * C && n <= 1284 * C), 33'h1);
        chk(33'(wd_n), 33'h0);
        strobe(0);
        strobe(3);
        waitv(2, 1'b1, 230 * C);
        chk(33'(n >= 216 * C && n <= 219 * C), 33'h1);
        // Low-load: short sleep, full wake
        pe_en <= 1'b0;
        negotiating <= 1'b0;
        apb(1'b1, negt_pkg::OFF_SLEEP, 32'h14);
        low_load <= 1'b1;
        waitv(3, 1'b1, 300 * C);
        waitv(3, 1'b0, 1100 * C);
        chk(33'(n >= 899 * C), 33'h1);
        repeat (2) @(negedge pclk);
        chk(33'(sleeping), 33'h1);
        waitv(3, 1'b1, 22 * C);
        chk(33'(n <= 21 * C), 33'h1);
        conclude();
    end
endmodule // tb_top
